// File: hw/dcrc_pkg.sv
// package: constants and carrier types for the converter update/reset/clear control
package dcrc_pkg;
  localparam int CLK_MHZ = 20;
  localparam int NUM_CH = 32;
  localparam int CH_W = 5;
  localparam int WORD_W = 16;
  // times in ns, counts derived from the 20 MHz clock
  localparam int RESET_SEQ_NS = 300000;
  localparam int RESET_SEQ_CYC = RESET_SEQ_NS * CLK_MHZ / 1000;
  localparam int STAGE_LONG_NS = 600;
  localparam int STAGE_LONG_CYC = STAGE_LONG_NS * CLK_MHZ / 1000;
  localparam int STAGE_SHORT_NS = 300;
  localparam int STAGE_SHORT_CYC = STAGE_SHORT_NS * CLK_MHZ / 1000;
  localparam int SEL_BUSY_NS = 500;
  localparam int SEL_BUSY_CYC = SEL_BUSY_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 13;
  // register defaults
  localparam logic [15:0] INPUT_DEFAULT = 16'h5554;
  localparam logic [15:0] GAIN_DEFAULT = 16'hFFFF;
  localparam logic [15:0] OFFS_DEFAULT = 16'h8000;
  localparam logic [16:0] MID_SCALE = 17'h08000;
  localparam logic [15:0] GROUND_CODE = 16'h0000;
  // write targets
  localparam logic [2:0] TGT_INPUT_A = 3'h0;
  localparam logic [2:0] TGT_INPUT_B = 3'h1;
  localparam logic [2:0] TGT_GAIN = 3'h2;
  localparam logic [2:0] TGT_OFFS = 3'h3;
  localparam logic [2:0] TGT_SELECT = 3'h4;
  // channel fan-out modes
  localparam logic [2:0] FAN_ONE = 3'h0;
  localparam logic [2:0] FAN_GROUP = 3'h1;
  localparam logic [2:0] FAN_SAME_0_3 = 3'h2;
  localparam logic [2:0] FAN_SAME_1_3 = 3'h3;
  localparam logic [2:0] FAN_ALL = 3'h4;

  typedef struct packed {
    logic valid;
    logic [2:0] target;
    logic [2:0] fan;
    logic [4:0] channel;
    logic [15:0] data;
  } dcrc_write_type;

  typedef enum logic [1:0] {
    DCRC_IDLE = 2'b00,
    DCRC_STAGE1 = 2'b01,
    DCRC_STAGE2 = 2'b10,
    DCRC_STAGE3 = 2'b11
  } dcrc_state_type;
endpackage

// File: hw/dcrc_core.sv
// core: reset sequence, clear, shared calculation engine, busy line and load transfer
`timescale 1ns/1ns

// Functional notes
// - reset pin rise restores input, gain, offset
// - reset sequence 300 us; no writes then
// - reset pin falling edge has no effect
// - outputs at ground until write and load
// - clear low switches outputs to ground
// - load during clear is discarded
// - clear release restores previous outputs
// - clear leaves all registers unchanged
// - each input, gain or offset write computes word, busy low
// - writes accepted while busy; no loads
// - busy open-drain, released when done
// - shared busy low defers load
// - load during busy pends, runs after
// - load held low updates on busy rise
// - select write drives busy about 500 ns
// - fan-out of 1, 3, 4, 8 or 32 channels
// - one multiplier, channels computed in sequence
// - busy per word 600 ns, plus 600+300
// - load transfers selected word only if written
// - select bit 0 takes A, 1 takes B
// - word = x*(m+1)/2^16 + c - 2^15
module dcrc_core
  import dcrc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dev_reset_n,
  input wire logic clear_outputs_n,
  input wire logic load_outputs_n,
  input wire dcrc_write_type wr,
  input wire logic busy_in,
  output logic busy_out,
  output logic busy_oe,
  output logic reset_active,
  output logic [NUM_CH-1:0] output_grounded,
  output logic [NUM_CH*WORD_W-1:0] output_words
);
  logic [WORD_W-1:0] input_word_a [NUM_CH];
  logic [WORD_W-1:0] input_word_b [NUM_CH];
  logic [WORD_W-1:0] gain_reg [NUM_CH];
  logic [WORD_W-1:0] offs_reg [NUM_CH];
  logic [WORD_W-1:0] computed_word_a [NUM_CH];
  logic [WORD_W-1:0] computed_word_b [NUM_CH];
  logic [WORD_W-1:0] out_reg [NUM_CH];
  logic [NUM_CH-1:0] sel_reg, dirty_a_reg, dirty_b_reg, queue_a_reg, queue_b_reg;
  logic dev_reset_d_reg, load_d_reg, pending_reg;
  logic [18:0] reset_cnt_reg;
  logic [CNT_W-1:0] stage_cnt_reg, sel_cnt_reg;
  dcrc_state_type state_reg;
  logic [CH_W-1:0] cur_ch_reg;
  logic cur_b_reg;
  logic [WORD_W-1:0] calc_result;
  logic [NUM_CH-1:0] fan_mask;
  logic reset_start, load_fall, own_busy, do_load, queue_any;
  logic [CH_W-1:0] next_ch;
  logic next_b;

  // channel mask for one write's fan-out
  function automatic logic [NUM_CH-1:0] fan_decode(input logic [2:0] fan, input logic [4:0] ch);
    logic [NUM_CH-1:0] m;
    m = '0;
    case (fan)
      FAN_ONE: m[ch] = 1'b1;
      FAN_GROUP: m = 32'h000000FF << {ch[1:0], 3'b000};
      FAN_SAME_0_3: m = 32'h01010101 << ch[2:0];
      FAN_SAME_1_3: m = 32'h01010100 << ch[2:0];
      FAN_ALL: m = 32'hFFFFFFFF;
      default: m = '0;
    endcase
    return m;
  endfunction

  // transfer arithmetic, clamped to the word range
  function automatic logic [WORD_W-1:0] calc_word(input logic [15:0] x, input logic [15:0] g,
                                                  input logic [15:0] c);
    logic [33:0] prod;
    logic signed [19:0] sum;
    prod = {18'h00000, x} * ({18'h00000, g} + 34'h000000001);
    sum = $signed({2'b00, prod[33:16]}) + $signed({4'h0, c}) - $signed({3'b000, MID_SCALE});
    if (sum < 0) return 16'h0000;
    if (sum > 20'sh0FFFF) return 16'hFFFF;
    return sum[15:0];
  endfunction

  assign reset_start = dev_reset_n && !dev_reset_d_reg;
  assign load_fall = !load_outputs_n && load_d_reg;
  assign fan_mask = fan_decode(wr.fan, wr.channel);
  assign queue_any = |(queue_a_reg | queue_b_reg);
  assign own_busy = (state_reg != DCRC_IDLE) || queue_any || (sel_cnt_reg != '0)
                    || (reset_cnt_reg != '0);
  assign busy_out = 1'b0;
  assign busy_oe = own_busy;
  // load proceeds only with the shared line high and clear inactive
  assign do_load = busy_in && !own_busy && clear_outputs_n
                   && (pending_reg || !load_outputs_n);
  assign reset_active = reset_cnt_reg != '0;
  // the only call of the transfer arithmetic, so one multiplier serves all channels
  assign calc_result = calc_word(cur_b_reg ? input_word_b[cur_ch_reg]
                                           : input_word_a[cur_ch_reg],
                                 gain_reg[cur_ch_reg], offs_reg[cur_ch_reg]);

  // edge detectors on the pins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dev_reset_d_reg <= 1'b1;
      load_d_reg <= 1'b1;
    end else begin
      dev_reset_d_reg <= dev_reset_n;
      load_d_reg <= load_outputs_n;
    end
  end

  // reset sequence timer; counts down from the rising edge
  always_ff @(posedge clk) begin
    if (!reset_n) reset_cnt_reg <= '0;
    else if (reset_start) reset_cnt_reg <= 19'(RESET_SEQ_CYC);
    else if (reset_cnt_reg != '0) reset_cnt_reg <= reset_cnt_reg - 19'h00001;
  end

  // pending load latch; set only when the load cannot run at once, clear drops it
  always_ff @(posedge clk) begin
    if (!reset_n) pending_reg <= 1'b0;
    else if (!clear_outputs_n) pending_reg <= 1'b0;
    else if (load_fall && !do_load) pending_reg <= 1'b1;
    else if (do_load) pending_reg <= 1'b0;
  end

  // user registers; writes taken even while busy, ignored during reset
  always_ff @(posedge clk) begin
    if (!reset_n || reset_start) begin
      for (int i = 0; i < NUM_CH; i++) begin
        input_word_a[i] <= INPUT_DEFAULT;
        input_word_b[i] <= INPUT_DEFAULT;
        gain_reg[i] <= GAIN_DEFAULT;
        offs_reg[i] <= OFFS_DEFAULT;
      end
      sel_reg <= '0;
    end else if (wr.valid && !reset_active) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (fan_mask[i]) begin
          case (wr.target)
            TGT_INPUT_A: input_word_a[i] <= wr.data;
            TGT_INPUT_B: input_word_b[i] <= wr.data;
            TGT_GAIN: gain_reg[i] <= wr.data;
            TGT_OFFS: offs_reg[i] <= wr.data;
            TGT_SELECT: sel_reg[i] <= wr.data[i[2:0]];
            default: ;
          endcase
        end
      end
    end
  end

  // select writes hold busy for a fixed interval
  always_ff @(posedge clk) begin
    if (!reset_n) sel_cnt_reg <= '0;
    else if (wr.valid && !reset_active && wr.target == TGT_SELECT)
      sel_cnt_reg <= CNT_W'(SEL_BUSY_CYC);
    else if (sel_cnt_reg != '0) sel_cnt_reg <= sel_cnt_reg - 1'b1;
  end

  // next queued channel, lowest index first, A before B
  always_comb begin
    next_ch = '0;
    next_b = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (queue_b_reg[i]) begin
        next_ch = CH_W'(i);
        next_b = 1'b1;
      end
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (queue_a_reg[i]) begin
        next_ch = CH_W'(i);
        next_b = 1'b0;
      end
    end
  end

  // calculation engine: one shared multiplier, one stage per word, two closing stages after the last
  always_ff @(posedge clk) begin
    if (!reset_n || reset_start) begin
      state_reg <= DCRC_IDLE;
      stage_cnt_reg <= '0;
      cur_ch_reg <= '0;
      cur_b_reg <= 1'b0;
    end else begin
      case (state_reg)
        DCRC_IDLE: begin
          if (queue_any) begin
            state_reg <= DCRC_STAGE1;
            cur_ch_reg <= next_ch;
            cur_b_reg <= next_b;
            // the queued cycle already counts toward the first stage
            stage_cnt_reg <= CNT_W'(STAGE_LONG_CYC - 2);
          end
        end
        DCRC_STAGE1: begin
          if (stage_cnt_reg != '0) stage_cnt_reg <= stage_cnt_reg - 1'b1;
          else begin
            if (queue_any) begin
              state_reg <= DCRC_STAGE1;
              cur_ch_reg <= next_ch;
              cur_b_reg <= next_b;
              stage_cnt_reg <= CNT_W'(STAGE_LONG_CYC - 1);
            end else begin
              state_reg <= DCRC_STAGE2;
              stage_cnt_reg <= CNT_W'(STAGE_LONG_CYC - 1);
            end
          end
        end
        DCRC_STAGE2: begin
          if (stage_cnt_reg != '0) stage_cnt_reg <= stage_cnt_reg - 1'b1;
          else begin
            state_reg <= DCRC_STAGE3;
            stage_cnt_reg <= CNT_W'(STAGE_SHORT_CYC - 1);
          end
        end
        DCRC_STAGE3: begin
          if (stage_cnt_reg != '0) stage_cnt_reg <= stage_cnt_reg - 1'b1;
          else state_reg <= DCRC_IDLE;
        end
        default: state_reg <= DCRC_IDLE;
      endcase
    end
  end

  // computed words land as each channel's first stage ends
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        computed_word_a[i] <= GROUND_CODE;
        computed_word_b[i] <= GROUND_CODE;
      end
    end else if (state_reg == DCRC_STAGE1 && stage_cnt_reg == '0) begin
      if (cur_b_reg) computed_word_b[cur_ch_reg] <= calc_result;
      else computed_word_a[cur_ch_reg] <= calc_result;
    end
  end

  // work queue and changed-word flags; a new write wins over removal
  always_ff @(posedge clk) begin
    if (!reset_n || reset_start) begin
      queue_a_reg <= '0;
      queue_b_reg <= '0;
      dirty_a_reg <= '0;
      dirty_b_reg <= '0;
    end else begin
      logic [NUM_CH-1:0] qa, qb, da, db;
      qa = queue_a_reg;
      qb = queue_b_reg;
      da = dirty_a_reg;
      db = dirty_b_reg;
      if (state_reg == DCRC_STAGE1 && stage_cnt_reg == '0) begin
        if (cur_b_reg) db[cur_ch_reg] = 1'b1;
        else da[cur_ch_reg] = 1'b1;
      end
      if ((state_reg == DCRC_IDLE || (state_reg == DCRC_STAGE1 && stage_cnt_reg == '0))
          && queue_any) begin
        if (next_b) qb[next_ch] = 1'b0;
        else qa[next_ch] = 1'b0;
      end
      if (do_load) begin
        da = '0;
        db = '0;
      end
      if (wr.valid && !reset_active) begin
        if (wr.target == TGT_INPUT_A || wr.target == TGT_GAIN || wr.target == TGT_OFFS)
          qa = qa | fan_mask;
        if (wr.target == TGT_INPUT_B || wr.target == TGT_GAIN || wr.target == TGT_OFFS)
          qb = qb | fan_mask;
      end
      queue_a_reg <= qa;
      queue_b_reg <= qb;
      dirty_a_reg <= da;
      dirty_b_reg <= db;
    end
  end

  // output registers; untouched by clear, ground after reset
  always_ff @(posedge clk) begin
    if (!reset_n || reset_start) begin
      for (int i = 0; i < NUM_CH; i++) out_reg[i] <= GROUND_CODE;
    end else if (do_load) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!sel_reg[i] && dirty_a_reg[i]) out_reg[i] <= computed_word_a[i];
        else if (sel_reg[i] && dirty_b_reg[i]) out_reg[i] <= computed_word_b[i];
      end
    end
  end

  // registered view of outputs; clear only switches the buffer input
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      output_grounded <= '1;
      output_words <= '0;
    end else begin
      output_grounded <= {NUM_CH{!clear_outputs_n}};
      for (int i = 0; i < NUM_CH; i++) output_words[i*WORD_W +: WORD_W] <= out_reg[i];
    end
  end

  a_clear_blocks_load: assert property (@(posedge clk) disable iff (!reset_n)
    !clear_outputs_n |-> !do_load) else $error("load during clear");
  a_busy_defers_load: assert property (@(posedge clk) disable iff (!reset_n)
    !busy_in |-> !do_load) else $error("load while busy line low");
  a_pending_clears: assert property (@(posedge clk) disable iff (!reset_n)
    !clear_outputs_n |=> !pending_reg) else $error("pending load kept in clear");
  a_sel_busy_len: assert property (@(posedge clk) disable iff (!reset_n)
    (wr.valid && !reset_active && wr.target == TGT_SELECT) |=> own_busy [*8])
    else $error("select busy too short");
  a_write_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (wr.valid && !reset_active && wr.target == TGT_INPUT_A && fan_mask != '0) |=> busy_oe)
    else $error("write did not raise busy");
  // a reset sequence restarts the engine, so it cancels these checks
  a_single_busy_max: assert property (@(posedge clk) disable iff (!reset_n || reset_start)
    (state_reg == DCRC_IDLE && queue_any)
    |-> ##[1:12] (state_reg == DCRC_STAGE1 && stage_cnt_reg == '0))
    else $error("first stage overran");
  a_final_stages: assert property (@(posedge clk) disable iff (!reset_n || reset_start)
    (state_reg == DCRC_STAGE1 && stage_cnt_reg == '0 && !queue_any)
    |=> (state_reg == DCRC_STAGE2) ##12 (state_reg == DCRC_STAGE3) ##6 (state_reg == DCRC_IDLE))
    else $error("final stages wrong length");
  a_busy_drive_low: assert property (@(posedge clk) disable iff (!reset_n)
    busy_oe |-> !busy_out) else $error("busy driven high");
  a_reset_holds: assert property (@(posedge clk) disable iff (!reset_n)
    reset_start |=> reset_active [*8]) else $error("reset sequence ended early");
  a_clear_keeps_out: assert property (@(posedge clk) disable iff (!reset_n)
    (!clear_outputs_n && !reset_start) |=> out_reg[0] == $past(out_reg[0]))
    else $error("clear changed output register");
  c_load_done: cover property (@(posedge clk) disable iff (!reset_n) do_load);
  c_pending_load: cover property (@(posedge clk) disable iff (!reset_n) pending_reg && do_load);
  c_all_fan: cover property (@(posedge clk) disable iff (!reset_n) wr.valid && wr.fan == FAN_ALL);
endmodule

// File: tb/dcrc_busy_model.sv
// partner model: shared busy wire with pull-up and a second device on it
`timescale 1ns/1ns
module dcrc_busy_model (
  input wire logic busy_oe,
  input wire logic busy_out,
  input wire logic other_hold,
  output logic busy_in
);
  // wired line: any driver pulls low, otherwise the pull-up wins
  always_comb begin
    busy_in = 1'b1;
    if (busy_oe && !busy_out) begin
      busy_in = 1'b0;
    end
    if (other_hold) begin
      busy_in = 1'b0;
    end
  end
endmodule

// File: tb/dcrc_core_test.sv
// testbench: reset, clear, busy and load behaviour of the converter control core
`timescale 1ns/1ns
module dcrc_core_test;
  import dcrc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic dev_reset_n = 1'b1;
  logic clear_outputs_n = 1'b1;
  logic load_outputs_n = 1'b1;
  logic other_hold = 1'b0;
  dcrc_write_type wr = '0;
  logic busy_in, busy_out, busy_oe, reset_active;
  logic [NUM_CH-1:0] output_grounded;
  logic [NUM_CH*WORD_W-1:0] output_words;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;

  always #25 clk = ~clk;

  dcrc_core dcrc_core_i (.clk(clk), .reset_n(reset_n), .dev_reset_n(dev_reset_n),
    .clear_outputs_n(clear_outputs_n), .load_outputs_n(load_outputs_n), .wr(wr),
    .busy_in(busy_in), .busy_out(busy_out), .busy_oe(busy_oe),
    .reset_active(reset_active), .output_grounded(output_grounded),
    .output_words(output_words));
  dcrc_busy_model dcrc_busy_model_i (.busy_oe(busy_oe), .busy_out(busy_out),
    .other_hold(other_hold), .busy_in(busy_in));

  function automatic logic [15:0] word(input int ch);
    return output_words[16*ch +: 16];
  endfunction

  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clk);
  endtask

  // one-cycle write request, fields held for the taking edge
  task automatic do_write(input logic [2:0] tgt, input logic [2:0] fan,
                          input logic [4:0] ch, input logic [15:0] data);
    @(negedge clk);
    wr <= '{valid: 1'b1, target: tgt, fan: fan, channel: ch, data: data};
    @(negedge clk);
    wr.valid <= 1'b0;
  endtask

  // measures how long this device pulls busy; limit guards a hang
  task automatic busy_width(input int lim, output int w);
    w = 0;
    for (int i = 0; i < lim + 4; i++) begin
      @(negedge clk);
      if (busy_oe === 1'b1) begin
        w++;
      end else if (w > 0) begin
        break;
      end
    end
    chk(w > 0 && w <= lim, "busy width out of range");
  endtask

  task automatic pulse_load();
    @(negedge clk);
    load_outputs_n <= 1'b0;
    @(negedge clk);
    load_outputs_n <= 1'b1;
    cycles(2);
  endtask

  task automatic t_single();
    chk(output_words === '0 && output_grounded === '0, "not at ground after reset");
    do_write(TGT_INPUT_A, FAN_ONE, 5'h03, 16'h1234);
    busy_width(2 * STAGE_LONG_CYC + STAGE_SHORT_CYC, n);
    chk(word(3) === 16'h0000, "output moved without load");
    pulse_load();
    chk(word(3) === 16'h1234 && word(0) === 16'h0000, "single load wrong");
    $display("test single done");
  endtask

  task automatic t_load_busy();
    do_write(TGT_INPUT_A, FAN_ONE, 5'h05, 16'h2222);
    do_write(TGT_INPUT_A, FAN_ONE, 5'h0A, 16'hA0A0);
    pulse_load();
    chk(busy_oe === 1'b1 && word(5) === 16'h0000, "load not deferred by busy");
    busy_width(3 * STAGE_LONG_CYC * 2 + STAGE_SHORT_CYC, n);
    cycles(3);
    chk(word(5) === 16'h2222 && word(10) === 16'hA0A0, "pending load lost");
    $display("test load during busy done");
  endtask

  task automatic t_shared_busy();
    other_hold <= 1'b1;
    do_write(TGT_INPUT_A, FAN_ONE, 5'h06, 16'h6666);
    cycles(40);
    chk(busy_oe === 1'b0 && busy_out === 1'b0, "own busy not released");
    pulse_load();
    chk(word(6) === 16'h0000, "load ran while line held");
    other_hold <= 1'b0;
    cycles(3);
    chk(word(6) === 16'h6666, "load not run on release");
    $display("test shared busy done");
  endtask

  task automatic t_held_load();
    load_outputs_n <= 1'b0;
    do_write(TGT_INPUT_A, FAN_ONE, 5'h09, 16'h0909);
    busy_width(2 * STAGE_LONG_CYC + STAGE_SHORT_CYC, n);
    cycles(3);
    chk(word(9) === 16'h0909, "held load did not update");
    load_outputs_n <= 1'b1;
    $display("test held load done");
  endtask

  task automatic t_clear();
    do_write(TGT_INPUT_A, FAN_ONE, 5'h07, 16'h7777);
    busy_width(2 * STAGE_LONG_CYC + STAGE_SHORT_CYC, n);
    clear_outputs_n <= 1'b0;
    cycles(2);
    chk(output_grounded === '1, "clear did not ground outputs");
    // host keeps clear low across an offset write of the default value
    do_write(TGT_OFFS, FAN_ONE, 5'h0C, OFFS_DEFAULT);
    busy_width(3 * STAGE_LONG_CYC + STAGE_SHORT_CYC, n);
    pulse_load();
    chk(word(7) === 16'h0000 && word(3) === 16'h1234, "registers changed in clear");
    clear_outputs_n <= 1'b1;
    cycles(2);
    chk(output_grounded === '0 && word(6) === 16'h6666, "outputs not restored");
    chk(word(7) === 16'h0000, "discarded load took effect");
    pulse_load();
    chk(word(7) === 16'h7777, "written word lost by clear");
    chk(word(12) === INPUT_DEFAULT, "offset write under clear lost");
    $display("test clear done");
  endtask

  task automatic t_all();
    do_write(TGT_INPUT_A, FAN_ALL, 5'h00, 16'h0100);
    busy_width(33 * STAGE_LONG_CYC + STAGE_SHORT_CYC, n);
    chk(n > 2 * STAGE_LONG_CYC + STAGE_SHORT_CYC, "all-channel busy too short");
    pulse_load();
    for (int c = 0; c < NUM_CH; c++) begin
      chk(word(c) === 16'h0100, "all-channel load wrong");
    end
    $display("test all channels done");
  endtask

  task automatic t_select();
    do_write(TGT_SELECT, FAN_GROUP, 5'h00, 16'h0008);
    busy_width(SEL_BUSY_CYC + 2, n);
    do_write(TGT_INPUT_B, FAN_ONE, 5'h03, 16'hABCD);
    busy_width(2 * STAGE_LONG_CYC + STAGE_SHORT_CYC, n);
    pulse_load();
    chk(word(3) === 16'hABCD && word(2) === 16'h0100, "select or unchanged skip wrong");
    $display("test select done");
  endtask

  task automatic t_dev_reset();
    dev_reset_n <= 1'b0;
    cycles(3);
    chk(reset_active === 1'b0 && word(3) === 16'hABCD, "falling reset acted");
    dev_reset_n <= 1'b1;
    cycles(2);
    chk(reset_active === 1'b1, "reset sequence not started");
    // this write lands inside the reset sequence and must be dropped
    do_write(TGT_INPUT_A, FAN_ONE, 5'h01, 16'h1111);
    n = 3;
    while (reset_active === 1'b1 && n < RESET_SEQ_CYC + 100) begin
      @(negedge clk);
      n++;
    end
    chk(n >= RESET_SEQ_CYC - 5 && n <= RESET_SEQ_CYC + 5, "reset length wrong");
    chk(output_words === '0, "outputs not at ground after reset");
    pulse_load();
    chk(word(1) === 16'h0000 && busy_oe === 1'b0, "write accepted during reset");
    $display("test device reset done");
  endtask

  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    cycles(8);
    reset_n <= 1'b1;
    cycles(2);
    t_single();
    t_load_busy();
    t_shared_busy();
    t_held_load();
    t_clear();
    t_all();
    t_select();
    t_dev_reset();
    complete_run();
  end

  // watchdog, well beyond the expected run of about 7000 cycles
  initial begin
    #(30000 * 50);
    n_mismatch++;
    complete_run();
  end
endmodule
